// ### rtl/cmad_core.sv
// Mode-dependent execution timing, addressing and branch table sequencing
// Functional notes
// - Add or subtract completes in one state
// - Multiplies take 3, 4, 4, 5 states
// - Divides take 12 and 20 states
// - Mode pins choose 64K or 16M space
// - Normal mode unavailable; advanced always used
// - Normal mode keeps low 16 address bits
// - Increment carry propagates into upper half
// - Normal vectors: 16-bit entries from zero
// - Normal indirect target: word in first 256
// - Advanced vectors: 32-bit, low 24 used
// - Advanced indirect target: longword, upper zeroed
// - Extended control stacked only when valid
// - Upper half independent or part of long
// - Accumulator instructions decode as valid
// - Sleep enters power-down; clock speed selectable
// - Fetch address forces bit zero low
`timescale 1ns/10ps
`include "cmad_regs.svh"
module cmad_core #(
    parameter bit NORMAL_EN = 1'b0          // Normal mode present in this build
) (
    input  wire logic              CLK_I,          // System clock, 10 MHz
    input  wire logic              ARST_N_I,       // Asynchronous reset, active low
    input  wire logic              MODE_I,         // Mode pin, high asks for normal mode
    input  wire logic              EXR_VALID_I,    // Extended control reg in use
    input  wire logic              WAKE_I,         // Leave power-down
    input  wire logic [2:0]        CLK_SEL_I,      // Requested clock speed
    input  wire logic              REQ_VALID_I,    // Operation offered
    input  wire cmad_pkg::cmad_req_t REQ_I,        // Operation and operands
    output logic                   REQ_READY_O,    // Operation taken when high
    output logic                   RES_VALID_O,    // Result pulse
    output cmad_pkg::cmad_res_t    RES_O,          // Result data
    output logic                   MODE_NRM_O,     // Normal mode active
    output logic                   SLEEP_O,        // Power-down state
    output logic [2:0]             CLK_SEL_O,      // Applied clock speed
    output logic [23:0]            FETCH_ADDR_O,   // Next instruction fetch address
    output cmad_pkg::cmad_mem_t    MEM_O,          // Memory bus request
    input  wire logic              MEM_ACK_I,      // Memory bus done
    input  wire logic [31:0]       MEM_RDATA_I     // Memory read data
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Fit an address to the active space
    function automatic logic [23:0] addr_fit(input logic [31:0] a, input logic nrm);
        addr_fit = a[23:0] & (nrm ? `CMAD_NRM_MASK : `CMAD_ADV_MASK);
    endfunction : addr_fit
    // Mask a value to the operand size
    function automatic logic [31:0] size_fit(input logic [31:0] v, input logic [1:0] sz);
        case (sz)
            2'h0:    size_fit = {24'h000000, v[7:0]};
            2'h1:    size_fit = {16'h0000, v[15:0]};
            default: size_fit = v;
        endcase
    endfunction : size_fit

    cmad_pkg::cmad_state_t s_r;             // Registered state
    cmad_pkg::cmad_state_t s_nxt;           // Next state
    logic                  fire;            // Request taken this cycle
    logic [15:0]           p_ub;            // Unsigned byte product
    logic [31:0]           p_uw;            // Unsigned word product
    logic signed [15:0]    p_sb;            // Signed byte product
    logic signed [31:0]    p_sw;            // Signed word product
    logic [15:0]           d_b;             // Byte divide {rem, quot}
    logic [31:0]           d_w;             // Word divide {rem, quot}
    logic [31:0]           step;            // Post-inc / pre-dec step

    // ----------------------------------------------------------------
    // Arithmetic
    // ----------------------------------------------------------------
    assign p_ub = REQ_I.a[7:0] * REQ_I.b[7:0];
    assign p_uw = REQ_I.a[15:0] * REQ_I.b[15:0];
    assign p_sb = $signed(REQ_I.a[7:0]) * $signed(REQ_I.b[7:0]);
    assign p_sw = $signed(REQ_I.a[15:0]) * $signed(REQ_I.b[15:0]);
    // Division by zero yields zero
    assign d_b = (REQ_I.b[7:0] == 8'h00) ? 16'h0000 :
                 {8'(REQ_I.a[15:0] % {8'h00, REQ_I.b[7:0]}),
                  8'(REQ_I.a[15:0] / {8'h00, REQ_I.b[7:0]})};
    assign d_w = (REQ_I.b[15:0] == 16'h0000) ? 32'h00000000 :
                 {16'(REQ_I.a % {16'h0000, REQ_I.b[15:0]}),
                  16'(REQ_I.a / {16'h0000, REQ_I.b[15:0]})};
    assign step = (REQ_I.size == 2'h0) ? 32'h00000001 :
                  (REQ_I.size == 2'h1) ? 32'h00000002 : 32'h00000004;

    assign fire = REQ_VALID_I && (s_r.st == cmad_pkg::ST_IDLE);

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt       = s_r;
        s_nxt.res_v = 1'b0;
        // Mode pin: third-stage change counts once stages two and three agree
        s_nxt.msync = {s_r.msync[1:0], MODE_I};
        if (s_r.msync[1] == s_r.msync[2]) begin
            s_nxt.mode_nrm = s_r.msync[2] & NORMAL_EN;
        end
        case (s_r.st)
            cmad_pkg::ST_IDLE: begin
                s_nxt.clk_sel = CLK_SEL_I;
                if (fire) begin
                    s_nxt.op      = REQ_I.op;
                    s_nxt.st      = cmad_pkg::ST_EXEC;
                    s_nxt.is_call = 1'b0;
                    s_nxt.res     = '0;
                    case (REQ_I.op)
                        // Sized add/sub; long size uses the upper half too
                        cmad_pkg::OP_ADD: begin
                            s_nxt.res.lo = size_fit(REQ_I.a + REQ_I.b, REQ_I.size);
                            s_nxt.cnt    = `CMAD_ST_ADD - 5'h01;
                        end
                        cmad_pkg::OP_SUB: begin
                            s_nxt.res.lo = size_fit(REQ_I.a - REQ_I.b, REQ_I.size);
                            s_nxt.cnt    = `CMAD_ST_ADD - 5'h01;
                        end
                        cmad_pkg::OP_MULU_B: begin
                            s_nxt.res.lo = {16'h0000, p_ub};
                            s_nxt.cnt    = `CMAD_ST_MULU_B - 5'h01;
                        end
                        cmad_pkg::OP_MULU_W: begin
                            s_nxt.res.lo = p_uw;
                            s_nxt.cnt    = `CMAD_ST_MULU_W - 5'h01;
                        end
                        cmad_pkg::OP_MULS_B: begin
                            s_nxt.res.lo = {16'h0000, p_sb};
                            s_nxt.cnt    = `CMAD_ST_MULS_B - 5'h01;
                        end
                        cmad_pkg::OP_MULS_W: begin
                            s_nxt.res.lo = p_sw;
                            s_nxt.cnt    = `CMAD_ST_MULS_W - 5'h01;
                        end
                        cmad_pkg::OP_DIV_B: begin
                            s_nxt.res.lo = {16'h0000, d_b};
                            s_nxt.cnt    = `CMAD_ST_DIV_B - 5'h01;
                        end
                        cmad_pkg::OP_DIV_W: begin
                            s_nxt.res.lo = d_w;
                            s_nxt.cnt    = `CMAD_ST_DIV_W - 5'h01;
                        end
                        // Accumulator group
                        cmad_pkg::OP_MAC: begin
                            s_nxt.acc = s_r.acc + {{32{p_sw[31]}}, p_sw};
                            s_nxt.cnt = `CMAD_ST_ACC - 5'h01;
                        end
                        cmad_pkg::OP_ACC_CLR: begin
                            s_nxt.acc = 64'h0000000000000000;
                            s_nxt.cnt = `CMAD_ST_ACC - 5'h01;
                        end
                        cmad_pkg::OP_ACC_LD: begin
                            s_nxt.acc = {REQ_I.a, REQ_I.b};
                            s_nxt.cnt = `CMAD_ST_ACC - 5'h01;
                        end
                        cmad_pkg::OP_ACC_ST: begin
                            s_nxt.res = {s_r.acc[31:0], s_r.acc[63:32]};
                            s_nxt.cnt = `CMAD_ST_ACC - 5'h01;
                        end
                        // Effective address: lo = address; hi = updated register for post-inc and pre-dec, zero for EA
                        cmad_pkg::OP_EA: begin
                            s_nxt.res.lo = {8'h00, addr_fit(REQ_I.a + REQ_I.b, s_r.mode_nrm)};
                            s_nxt.cnt    = `CMAD_ST_ADD - 5'h01;
                        end
                        cmad_pkg::OP_POSTINC: begin
                            s_nxt.res.lo = {8'h00, addr_fit(REQ_I.a, s_r.mode_nrm)};
                            s_nxt.res.hi = REQ_I.a + step;
                            s_nxt.cnt    = `CMAD_ST_ADD - 5'h01;
                        end
                        cmad_pkg::OP_PREDEC: begin
                            s_nxt.res.lo = {8'h00, addr_fit(REQ_I.a - step, s_r.mode_nrm)};
                            s_nxt.res.hi = REQ_I.a - step;
                            s_nxt.cnt    = `CMAD_ST_ADD - 5'h01;
                        end
                        // Indirect branches through the first 256 bytes
                        cmad_pkg::OP_JUMP_IND, cmad_pkg::OP_CALL_IND: begin
                            s_nxt.tbl_addr = `CMAD_TBL_BASE | {16'h0000, REQ_I.a[7:0]};
                            s_nxt.sp       = REQ_I.c;
                            if (REQ_I.op == cmad_pkg::OP_CALL_IND) begin
                                s_nxt.is_call   = 1'b1;
                                s_nxt.sp        = REQ_I.c - `CMAD_LONG_SLOT;
                                s_nxt.mem       = {1'b1, 1'b1, 1'b1,
                                    addr_fit(REQ_I.c - `CMAD_LONG_SLOT, s_r.mode_nrm),
                                    {8'h00, s_r.ip}};
                                s_nxt.st        = cmad_pkg::ST_PUSH_IP;
                            end else begin
                                s_nxt.mem = {1'b1, 1'b0, ~s_r.mode_nrm,
                                    `CMAD_TBL_BASE | {16'h0000, REQ_I.a[7:0]}, 32'h00000000};
                                s_nxt.st  = cmad_pkg::ST_RD_TBL;
                            end
                        end
                        // Exception entry: frame {ccr, ip} in frame
                        cmad_pkg::OP_EXCEPT: begin
                            s_nxt.frame    = {REQ_I.b[7:0], s_r.ip};
                            s_nxt.tbl_addr = `CMAD_TBL_BASE | (s_r.mode_nrm ?
                                {15'h0000, REQ_I.vec, 1'b0} : {14'h0000, REQ_I.vec, 2'h0});
                            if (EXR_VALID_I) begin
                                s_nxt.sp  = REQ_I.c - `CMAD_EXR_SLOT;
                                s_nxt.mem = {1'b1, 1'b1, 1'b0,
                                    addr_fit(REQ_I.c - `CMAD_EXR_SLOT, s_r.mode_nrm),
                                    {24'h000000, REQ_I.b[15:8]}};
                                s_nxt.st  = cmad_pkg::ST_PUSH_EXR;
                            end else begin
                                s_nxt.sp  = REQ_I.c - `CMAD_LONG_SLOT;
                                s_nxt.mem = {1'b1, 1'b1, 1'b1,
                                    addr_fit(REQ_I.c - `CMAD_LONG_SLOT, s_r.mode_nrm),
                                    {REQ_I.b[7:0], s_r.ip}};
                                s_nxt.st  = cmad_pkg::ST_PUSH_IP;
                            end
                        end
                        cmad_pkg::OP_SLEEP: begin
                            s_nxt.st = cmad_pkg::ST_SLEEP;
                        end
                        default: begin
                            s_nxt.cnt = 5'h00;
                        end
                    endcase
                end
            end
            // Count out the execution states
            cmad_pkg::ST_EXEC: begin
                if (s_r.cnt == 5'h00) begin
                    s_nxt.res_v = 1'b1;
                    s_nxt.st    = cmad_pkg::ST_IDLE;
                end else begin
                    s_nxt.cnt = s_r.cnt - 5'h01;
                end
            end
            // Extended control written, now the long frame
            cmad_pkg::ST_PUSH_EXR: begin
                if (MEM_ACK_I) begin
                    s_nxt.sp  = s_r.sp - `CMAD_LONG_SLOT;
                    s_nxt.mem = {1'b1, 1'b1, 1'b1,
                        addr_fit(s_r.sp - `CMAD_LONG_SLOT, s_r.mode_nrm), s_r.frame};
                    s_nxt.st  = cmad_pkg::ST_PUSH_IP;
                end
            end
            // Frame written, now read the table entry
            cmad_pkg::ST_PUSH_IP: begin
                if (MEM_ACK_I) begin
                    s_nxt.mem = {1'b1, 1'b0, ~s_r.mode_nrm, s_r.tbl_addr, 32'h00000000};
                    s_nxt.st  = cmad_pkg::ST_RD_TBL;
                end
            end
            // Entry arrives: normal uses a word, advanced the low 24 bits
            cmad_pkg::ST_RD_TBL: begin
                if (MEM_ACK_I) begin
                    s_nxt.ip     = s_r.mode_nrm ? {8'h00, MEM_RDATA_I[15:0]}
                                                : MEM_RDATA_I[23:0];
                    s_nxt.res.lo = s_r.sp;
                    s_nxt.mem    = '0;
                    s_nxt.res_v  = 1'b1;
                    s_nxt.st     = cmad_pkg::ST_IDLE;
                end
            end
            // Power-down until woken
            cmad_pkg::ST_SLEEP: begin
                if (WAKE_I) begin
                    s_nxt.res_v = 1'b1;
                    s_nxt.st    = cmad_pkg::ST_IDLE;
                end
            end
            default: begin
                s_nxt.st = cmad_pkg::ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign REQ_READY_O  = (s_r.st == cmad_pkg::ST_IDLE);
    assign RES_VALID_O  = s_r.res_v;
    assign RES_O        = s_r.res;
    assign MODE_NRM_O   = s_r.mode_nrm;
    assign SLEEP_O      = (s_r.st == cmad_pkg::ST_SLEEP);
    assign CLK_SEL_O    = s_r.clk_sel;
    assign FETCH_ADDR_O = {s_r.ip[23:1], 1'b0};
    assign MEM_O        = s_r.mem;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I);
    sequence take_s(cmad_pkg::cmad_op_t o);
        fire && REQ_I.op == o;
    endsequence
    // No result pulse in this cycle
    sequence quiet_s;
        !RES_VALID_O;
    endsequence
    // The pulse is registered at the edge that ends the last state, so it is
    // sampled one edge later; the taking edge itself may still show the
    // previous result when requests run back to back
    add_one_state_a: assert property (take_s(cmad_pkg::OP_ADD) |=> ##1 RES_VALID_O)
        else $error("add not done in one state");
    mulub_three_a: assert property (take_s(cmad_pkg::OP_MULU_B)
        |=> ##1 quiet_s [*2] ##1 RES_VALID_O)
        else $error("unsigned byte multiply not three states");
    mulsw_five_a: assert property (take_s(cmad_pkg::OP_MULS_W)
        |=> ##1 quiet_s [*4] ##1 RES_VALID_O)
        else $error("signed word multiply not five states");
    divw_twenty_a: assert property (take_s(cmad_pkg::OP_DIV_W) |-> ##21 RES_VALID_O)
        else $error("word divide not twenty states");
    adv_forced_a: assert property (!NORMAL_EN |-> !MODE_NRM_O)
        else $error("normal mode active while absent");
    ea_trunc_a: assert property (take_s(cmad_pkg::OP_EA) ##0 MODE_NRM_O
        |=> RES_O.lo[31:16] == 16'h0000)
        else $error("normal address wider than 16 bits");
    exr_skip_a: assert property (take_s(cmad_pkg::OP_EXCEPT) ##0 !EXR_VALID_I
        |=> MEM_O.we && MEM_O.long_acc)
        else $error("extended control stacked while invalid");
    vec_read_a: assert property (MEM_O.req && !MEM_O.we && !MODE_NRM_O
        && s_r.st == cmad_pkg::ST_RD_TBL |-> MEM_O.addr[23:10] == 14'h0000)
        else $error("table read outside first entries");
    fetch_even_a: assert property (FETCH_ADDR_O[0] == 1'b0)
        else $error("fetch address odd");
    sleep_hold_a: assert property (take_s(cmad_pkg::OP_SLEEP) |=> SLEEP_O && !REQ_READY_O)
        else $error("sleep not entered");
    ind_upper_a: assert property (s_r.st == cmad_pkg::ST_RD_TBL && MEM_ACK_I && !MODE_NRM_O
        |=> {8'h00, FETCH_ADDR_O} == ($past(MEM_RDATA_I) & 32'h00fffffe))
        else $error("indirect target not taken");
endmodule : cmad_core

// ### rtl/cmad_regs.svh
// Constants of the mode and addressing core: state counts, table layout, widths
`ifndef CMAD_REGS_SVH
`define CMAD_REGS_SVH
// Execution states per operation
`define CMAD_ST_ADD     5'h01
`define CMAD_ST_MULU_B  5'h03
`define CMAD_ST_MULU_W  5'h04
`define CMAD_ST_MULS_B  5'h04
`define CMAD_ST_MULS_W  5'h05
`define CMAD_ST_DIV_B   5'h0c
`define CMAD_ST_DIV_W   5'h14
`define CMAD_ST_ACC     5'h01
// Vector and indirect table layout
`define CMAD_TBL_BASE   24'h000000
`define CMAD_VEC_SH_ADV 2
`define CMAD_VEC_SH_NRM 1
// Stack slot sizes in bytes
`define CMAD_EXR_SLOT   32'h00000002
`define CMAD_LONG_SLOT  32'h00000004
// Address limits
`define CMAD_NRM_MASK   24'h00ffff
`define CMAD_ADV_MASK   24'hffffff
`endif

// ### rtl/cmad_pkg.sv
// Types of the mode and addressing core
package cmad_pkg;
    // Operations accepted on the request port
    typedef enum logic [4:0] {
        OP_ADD, OP_SUB, OP_MULU_B, OP_MULU_W, OP_MULS_B, OP_MULS_W,
        OP_DIV_B, OP_DIV_W, OP_MAC, OP_ACC_CLR, OP_ACC_LD, OP_ACC_ST,
        OP_EA, OP_POSTINC, OP_PREDEC, OP_JUMP_IND, OP_CALL_IND,
        OP_EXCEPT, OP_SLEEP
    } cmad_op_t;
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_EXEC, ST_PUSH_EXR, ST_PUSH_IP, ST_RD_TBL, ST_SLEEP
    } cmad_st_t;
    // Request: operands, size (0 byte, 1 word, 2 long), vector number
    typedef struct packed {
        cmad_op_t    op;
        logic [1:0]  size;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] c;
        logic [7:0]  vec;
    } cmad_req_t;
    // Result of one operation
    typedef struct packed {
        logic [31:0] lo;
        logic [31:0] hi;
    } cmad_res_t;
    // Memory bus request
    typedef struct packed {
        logic        req;
        logic        we;
        logic        long_acc;
        logic [23:0] addr;
        logic [31:0] wdata;
    } cmad_mem_t;
    // Whole state of the core
    typedef struct packed {
        cmad_st_t    st;
        cmad_op_t    op;
        logic [4:0]  cnt;
        logic        is_call;
        logic        res_v;
        cmad_res_t   res;
        logic [63:0] acc;
        logic [23:0] ip;
        logic [31:0] sp;
        logic [31:0] frame;
        logic [23:0] tbl_addr;
        cmad_mem_t   mem;
        logic [2:0]  msync;
        logic        mode_nrm;
        logic [2:0]  clk_sel;
    } cmad_state_t;
endpackage : cmad_pkg

// ### sim/cmad_mem_model.sv
// Behavioural program and data memory on the core's bus
`timescale 1ns/10ps
module cmad_mem_model (
    input  wire logic                clk_i,     // System clock
    input  wire logic                arst_n_i,  // Reset, active low
    input  wire cmad_pkg::cmad_mem_t mem_i,     // Access from the core
    input  wire logic                slow_i,    // High adds three wait cycles
    output logic                     ack_o,     // One-cycle completion pulse
    output logic [31:0]              rdata_o,   // Read data, scrambled outside ack
    output logic [7:0]               n_wr_o     // Writes completed
);
    logic [1:0] wait_r;                         // Wait cycles spent
    // ----------------------------------------
    // Answer each access promptly or slowly
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack_o   <= 1'b0;
            rdata_o <= 32'h0;
            n_wr_o  <= 8'h0;
            wait_r  <= 2'h0;
        end else if (ack_o) begin
            ack_o   <= 1'b0;
            rdata_o <= ~rdata_o;                // Stale data never lingers
        end else if (mem_i.req && (!slow_i || wait_r == 2'h3)) begin
            ack_o   <= 1'b1;
            wait_r  <= 2'h0;
            // Junk top byte, odd target: {12, low address byte, 37}
            rdata_o <= {8'ha5, 8'h12, mem_i.addr[7:0], 8'h37};
            n_wr_o  <= n_wr_o + {7'h0, mem_i.we};
        end else begin
            wait_r  <= mem_i.req ? wait_r + 2'h1 : 2'h0;
            rdata_o <= ~rdata_o;
        end
    end
endmodule : cmad_mem_model

// ### sim/cmad_core_bench.sv
// Self-checking bench of the mode and addressing core
`timescale 1ns/10ps
module cmad_core_bench;
    typedef struct {logic [31:0] lo; logic [31:0] mask; int lat;} cmad_exp_t;
    logic                clk, arst_n, mode, exr_valid, wake, req_valid, slow;
    logic [2:0]          clk_sel, clk_sel_o;
    cmad_pkg::cmad_req_t req;
    cmad_pkg::cmad_res_t res;
    cmad_pkg::cmad_mem_t mem;
    logic                ready, res_valid, mode_nrm, sleep, ack;
    logic [23:0]         fetch;
    logic [31:0]         rdata, a, b, seed;
    logic [7:0]          n_wr, n0;
    cmad_exp_t           expq[$];                 // Expected results, oldest first
    cmad_exp_t           e;
    int                  n_mismatch, comparisons, cnt, lat_seen;

    cmad_core cmad_core_i (.CLK_I(clk), .ARST_N_I(arst_n), .MODE_I(mode), .EXR_VALID_I(exr_valid),
        .WAKE_I(wake), .CLK_SEL_I(clk_sel), .REQ_VALID_I(req_valid), .REQ_I(req),
        .REQ_READY_O(ready), .RES_VALID_O(res_valid), .RES_O(res), .MODE_NRM_O(mode_nrm),
        .SLEEP_O(sleep), .CLK_SEL_O(clk_sel_o), .FETCH_ADDR_O(fetch), .MEM_O(mem),
        .MEM_ACK_I(ack), .MEM_RDATA_I(rdata));
    cmad_mem_model cmad_mem_model_i (.clk_i(clk), .arst_n_i(arst_n), .mem_i(mem),
        .slow_i(slow), .ack_o(ack), .rdata_o(rdata), .n_wr_o(n_wr));

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    // Offer one operation, hold it until taken, note the expected result
    task automatic run(input cmad_pkg::cmad_op_t op, input logic [1:0] sz, input logic [31:0] x,
                       input logic [31:0] y, input logic [31:0] c, input logic [31:0] lo,
                       input logic [31:0] mask, input int lat);
        int n;
        @(negedge clk);
        req_valid = 1'b1;
        req = '{op, sz, x, y, c, 8'h05};
        for (n = 0; ready !== 1'b1; n++) begin
            if (n > 200) begin
                n_mismatch++;
                report_and_stop();
            end
            @(negedge clk);
        end
        expq.push_back('{lo, mask, lat});
        @(negedge clk);
        req_valid = 1'b0;
    endtask : run
    task automatic wait_empty();
        for (int n = 0; expq.size() != 0; n++) begin
            if (n > 200) begin
                n_mismatch++;
                report_and_stop();
            end
            @(negedge clk);
        end
    endtask : wait_empty
    // ----------------------------------------
    // Cycles from the taking edge to each edge
    // ----------------------------------------
    always @(posedge clk) begin
        lat_seen <= cnt + 1;
        cnt <= (req_valid && ready) ? 0 : cnt + 1;
    end
    // Compare each result pulse with the oldest note
    always @(negedge clk) begin
        if (res_valid === 1'b1) begin
            if (expq.size() == 0) begin
                chk("unexpected result", 32'h1, 32'h0);
            end else begin
                e = expq.pop_front();
                chk("result", e.lo & e.mask, res.lo & e.mask);
                if (e.lat != 0) chk("latency", 32'(e.lat), 32'(lat_seen));
            end
        end
    end
    initial begin
        {arst_n, exr_valid, wake, req_valid, slow, clk_sel, req} = '0;
        mode = 1'b1;                               // Normal mode asked for but absent
        seed = 32'h00015c90;
        cnt = 0;
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        for (int i = 0; i < 6; i++) begin
            a = rnd();
            b = rnd();
            run(i < 3 ? cmad_pkg::OP_ADD : cmad_pkg::OP_SUB, 2'(i % 3), a, b, 0,
                i < 3 ? a + b : a - b, i % 3 == 0 ? 32'hff : i % 3 == 1 ? 32'hffff : '1, 1);
        end
        for (int i = 0; i < 4; i++) begin
            a = rnd();
            b = rnd();
            run(cmad_pkg::cmad_op_t'(i + 2), 2'h1, a, b, 0,
                i == 0 ? a[7:0] * b[7:0] : i == 1 ? a[15:0] * b[15:0] :
                i == 2 ? {16'h0, 16'({{8{a[7]}}, a[7:0]} * {{8{b[7]}}, b[7:0]})} :
                {{16{a[15]}}, a[15:0]} * {{16{b[15]}}, b[15:0]},
                '1, i == 0 ? 3 : i == 3 ? 5 : 4);
        end
        a = rnd() & 32'h0fff;
        b = (rnd() & 32'hff) | 32'h10;
        run(cmad_pkg::OP_DIV_B, 2'h0, a, b, 0, {16'h0, 8'(a % b), 8'(a / b)}, 32'hffff, 12);
        a = rnd() & 32'h0fffffff;
        b = (rnd() & 32'hffff) | 32'h1000;
        run(cmad_pkg::OP_DIV_W, 2'h1, a, b, 0, {16'(a % b), 16'(a / b)}, '1, 20);
        run(cmad_pkg::OP_ACC_LD, 2'h2, a, b, 0, 0, 0, 1);
        run(cmad_pkg::OP_MAC, 2'h1, 32'h3, 32'h5, 0, 0, 0, 1);
        run(cmad_pkg::OP_ACC_ST, 2'h2, 0, 0, 0, b + 32'hf, '1, 1);
        chk("acc upper", a, res.hi);
        run(cmad_pkg::OP_ACC_CLR, 2'h2, 0, 0, 0, 0, 0, 1);
        run(cmad_pkg::OP_ACC_ST, 2'h2, 0, 0, 0, 0, '1, 1);
        run(cmad_pkg::OP_EA, 2'h2, 32'h00fff000, 32'h2000, 0, 32'h00001000, '1, 1);
        run(cmad_pkg::OP_POSTINC, 2'h2, 32'h0000fffc, 0, 0, 32'h0000fffc, '1, 1);
        chk("post step", 32'h00010000, res.hi);
        run(cmad_pkg::OP_PREDEC, 2'h1, 32'h00010000, 0, 0, 32'h0000fffe, '1, 1);
        chk("pre step", 32'h0000fffe, res.hi);
        chk("normal mode flag", 0, {31'h0, mode_nrm});
        slow = 1'b1;
        run(cmad_pkg::OP_JUMP_IND, 2'h2, 32'h41, 0, 32'h2000, 0, 0, 0);
        wait_empty();
        chk("jump fetch", 32'h124136, {8'h0, fetch});
        run(cmad_pkg::OP_CALL_IND, 2'h2, 32'h80, 0, 32'h3000, 32'h2ffc, '1, 0);
        wait_empty();
        chk("call fetch", 32'h128036, {8'h0, fetch});
        for (int x = 1; x >= 0; x--) begin
            exr_valid = x[0];
            slow = x[0];
            n0 = n_wr;
            run(cmad_pkg::OP_EXCEPT, 2'h2, 0, 0, 32'h2000, x ? 32'h1ffa : 32'h1ffc, '1, 0);
            wait_empty();
            chk("vector fetch", 32'h121436, {8'h0, fetch});
            chk("stack writes", x ? 2 : 1, {24'h0, n_wr - n0});
        end
        clk_sel = 3'h5;
        run(cmad_pkg::OP_SLEEP, 2'h0, 0, 0, 0, 0, 0, 0);
        repeat (3) @(negedge clk);
        chk("sleeping", 32'h2, {30'h0, sleep, ready});
        wake = 1'b1;
        wait_empty();
        wake = 1'b0;
        @(negedge clk);
        chk("awake", 32'h05, {28'h0, sleep, clk_sel_o});
        report_and_stop();
    end
endmodule : cmad_core_bench
